// *** shared/aimux_map.vh ***
`ifndef AIMUX_MAP_VH
`define AIMUX_MAP_VH
`define AIMUX_ADDR_PAIR 8'hba
`define AIMUX_ADDR_CHAN 8'hbb
`define AIMUX_ADDR_PINS 8'hbd
`define AIMUX_ADDR_AMP 8'hd6
`define AIMUX_RST_BYTE 8'h00
`define AIMUX_RST_NIB 4'h0
`define AIMUX_RSV_AMP 3'h0
`define AIMUX_LOW_NIB 4'hf
`define AIMUX_BIT_LO_PAIR 0
`define AIMUX_BIT_HI_PAIR 1
`define AIMUX_BIT_HV_DIFF 2
`define AIMUX_BIT_PORT_DIFF 3
`define AIMUX_BIT_AMP_EN 7
`define AIMUX_BIT_TEMP 3
`define AIMUX_CODE_AIN0 4'h0
`define AIMUX_CODE_AIN1 4'h1
`define AIMUX_CODE_AIN2 4'h2
`define AIMUX_CODE_AIN3 4'h3
`define AIMUX_CODE_HV 4'h4
`define AIMUX_CODE_GND 4'h5
`define AIMUX_CODE_EVEN 4'h6
`define AIMUX_CODE_ODD 4'h7
`define AIMUX_SRC_NONE 4'h0
`define AIMUX_SRC_AIN0 4'h1
`define AIMUX_SRC_AIN1 4'h2
`define AIMUX_SRC_AIN2 4'h3
`define AIMUX_SRC_AIN3 4'h4
`define AIMUX_SRC_HV 4'h5
`define AIMUX_SRC_GND 4'h6
`define AIMUX_SRC_EVEN 4'h7
`define AIMUX_SRC_ODD 4'h8
`define AIMUX_SRC_TEMP 4'h9
`define AIMUX_SRC_HIGHVOLT_COMMON_REF 4'ha
`endif

// *** rtl/aimux_select.v ***
// Function
// - top four bits of pairing and channel registers read zero, writes ignored
// - pairing bit 3 makes even/odd port inputs a differential pair
// - pairing bit 2 makes amplifier measurement two's-complement differential
// - pairing bit 1 pairs external inputs two and three
// - pairing bit 0 pairs external inputs zero and one
// - differential channel gives two's-complement data, otherwise unsigned
// - channel register holds a writable four-bit code, all codes legal
// - codes 0-3 pick external inputs; paired upper code selects nothing
// - code 4 amplifier, code 5 ground, top bit set selects temperature sensor
// - codes 6/7 pick even/odd port input; paired code 7 selects nothing
// - amplifier differential routes reference to negative input; code 5 selects nothing
// - pin select bit n connects port pin n as analog input; reset zero
// - enabled even pins join even input, odd pins join odd input
// - amplifier enabled only while control bit 7 set; control resets zero
// - four-bit gain code selects one of sixteen amplifier gains
`timescale 1ns/1ns
`include "aimux_map.vh"
module aimux_select #(
	parameter DW = 8
) (
	input wire clock,
	input wire srst,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_addr,
	input wire [DW-1:0] sfr_wdata,
	output reg [DW-1:0] sfr_rdata,
	output reg [3:0] pos_source,
	output reg [3:0] neg_source,
	output reg diff_result,
	output reg [7:0] pin_analog_enable,
	output reg even_port_input_active,
	output reg odd_port_input_active,
	output reg amp_enable,
	output reg [3:0] amp_gain_code
);
	reg [3:0] pair_r;
	reg [3:0] chan_r;
	reg [7:0] pins_r;
	reg amp_en_r;
	reg [3:0] gain_r;
	reg [3:0] pos_nxt;
	reg [3:0] neg_nxt;
	reg diff_nxt;
	reg [DW-1:0] rdata_nxt;
	wire [7:0] even_mask;
	wire [7:0] odd_mask;

	// write side of the register file
	always @(posedge clock) begin
		if (srst) begin
			pair_r <= `AIMUX_RST_NIB;
			chan_r <= `AIMUX_RST_NIB;
			pins_r <= `AIMUX_RST_BYTE;
			amp_en_r <= 1'b0;
			gain_r <= `AIMUX_RST_NIB;
		end else if (sfr_wr) begin
			case (sfr_addr)
			`AIMUX_ADDR_PAIR: begin
				pair_r <= sfr_wdata[3:0] & `AIMUX_LOW_NIB;
			end
			`AIMUX_ADDR_CHAN: begin
				chan_r <= sfr_wdata[3:0];
			end
			`AIMUX_ADDR_PINS: begin
				pins_r <= sfr_wdata[7:0];
			end
			`AIMUX_ADDR_AMP: begin
				amp_en_r <= sfr_wdata[`AIMUX_BIT_AMP_EN];
				gain_r <= sfr_wdata[3:0];
			end
			default: begin
			end
			endcase
		end
	end

	// read mux: addressed register, unused bits tied low
	always @* begin
		rdata_nxt = {DW{1'b0}};
		case (sfr_addr)
		`AIMUX_ADDR_PAIR: begin
			rdata_nxt = {`AIMUX_RST_NIB, pair_r};
		end
		`AIMUX_ADDR_CHAN: begin
			rdata_nxt = {`AIMUX_RST_NIB, chan_r};
		end
		`AIMUX_ADDR_PINS: begin
			rdata_nxt = pins_r;
		end
		`AIMUX_ADDR_AMP: begin
			rdata_nxt = {amp_en_r, `AIMUX_RSV_AMP, gain_r};
		end
		default: begin
			rdata_nxt = {DW{1'b0}};
		end
		endcase
	end

	// read data flop, holds until the next read
	always @(posedge clock) begin
		if (srst) begin
			sfr_rdata <= {DW{1'b0}};
		end else if (sfr_rd) begin
			sfr_rdata <= rdata_nxt;
		end
	end

	// channel decode; every branch sets all three steering values
	always @* begin
		pos_nxt = `AIMUX_SRC_NONE;
		neg_nxt = `AIMUX_SRC_GND;
		diff_nxt = 1'b0;
		if (chan_r[`AIMUX_BIT_TEMP]) begin
			pos_nxt = `AIMUX_SRC_TEMP;
			neg_nxt = `AIMUX_SRC_GND;
			diff_nxt = 1'b0;
		end else begin
			case (chan_r)
			`AIMUX_CODE_AIN0: begin
				if (pair_r[`AIMUX_BIT_LO_PAIR]) begin
					pos_nxt = `AIMUX_SRC_AIN0;
					neg_nxt = `AIMUX_SRC_AIN1;
					diff_nxt = 1'b1;
				end else begin
					pos_nxt = `AIMUX_SRC_AIN0;
					neg_nxt = `AIMUX_SRC_GND;
					diff_nxt = 1'b0;
				end
			end
			`AIMUX_CODE_AIN1: begin
				if (pair_r[`AIMUX_BIT_LO_PAIR]) begin
					pos_nxt = `AIMUX_SRC_NONE;
					neg_nxt = `AIMUX_SRC_NONE;
					diff_nxt = 1'b0;
				end else begin
					pos_nxt = `AIMUX_SRC_AIN1;
					neg_nxt = `AIMUX_SRC_GND;
					diff_nxt = 1'b0;
				end
			end
			`AIMUX_CODE_AIN2: begin
				if (pair_r[`AIMUX_BIT_HI_PAIR]) begin
					pos_nxt = `AIMUX_SRC_AIN2;
					neg_nxt = `AIMUX_SRC_AIN3;
					diff_nxt = 1'b1;
				end else begin
					pos_nxt = `AIMUX_SRC_AIN2;
					neg_nxt = `AIMUX_SRC_GND;
					diff_nxt = 1'b0;
				end
			end
			`AIMUX_CODE_AIN3: begin
				if (pair_r[`AIMUX_BIT_HI_PAIR]) begin
					pos_nxt = `AIMUX_SRC_NONE;
					neg_nxt = `AIMUX_SRC_NONE;
					diff_nxt = 1'b0;
				end else begin
					pos_nxt = `AIMUX_SRC_AIN3;
					neg_nxt = `AIMUX_SRC_GND;
					diff_nxt = 1'b0;
				end
			end
			`AIMUX_CODE_HV: begin
				if (pair_r[`AIMUX_BIT_HV_DIFF]) begin
					pos_nxt = `AIMUX_SRC_HV;
					neg_nxt = `AIMUX_SRC_HIGHVOLT_COMMON_REF;
					diff_nxt = 1'b1;
				end else begin
					pos_nxt = `AIMUX_SRC_HV;
					neg_nxt = `AIMUX_SRC_GND;
					diff_nxt = 1'b0;
				end
			end
			`AIMUX_CODE_GND: begin
				if (pair_r[`AIMUX_BIT_HV_DIFF]) begin
					pos_nxt = `AIMUX_SRC_NONE;
					neg_nxt = `AIMUX_SRC_NONE;
					diff_nxt = 1'b0;
				end else begin
					pos_nxt = `AIMUX_SRC_GND;
					neg_nxt = `AIMUX_SRC_GND;
					diff_nxt = 1'b0;
				end
			end
			`AIMUX_CODE_EVEN: begin
				if (pair_r[`AIMUX_BIT_PORT_DIFF]) begin
					pos_nxt = `AIMUX_SRC_EVEN;
					neg_nxt = `AIMUX_SRC_ODD;
					diff_nxt = 1'b1;
				end else begin
					pos_nxt = `AIMUX_SRC_EVEN;
					neg_nxt = `AIMUX_SRC_GND;
					diff_nxt = 1'b0;
				end
			end
			`AIMUX_CODE_ODD: begin
				if (pair_r[`AIMUX_BIT_PORT_DIFF]) begin
					pos_nxt = `AIMUX_SRC_NONE;
					neg_nxt = `AIMUX_SRC_NONE;
					diff_nxt = 1'b0;
				end else begin
					pos_nxt = `AIMUX_SRC_ODD;
					neg_nxt = `AIMUX_SRC_GND;
					diff_nxt = 1'b0;
				end
			end
			default: begin
				pos_nxt = `AIMUX_SRC_NONE;
				neg_nxt = `AIMUX_SRC_GND;
				diff_nxt = 1'b0;
			end
			endcase
		end
	end

	// even and odd pin groups
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : pin_grp
			assign even_mask[g] = (g % 2 == 0) ? pins_r[g] : 1'b0;
			assign odd_mask[g] = (g % 2 == 1) ? pins_r[g] : 1'b0;
		end
	endgenerate

	// registered steering outputs
	always @(posedge clock) begin
		if (srst) begin
			pos_source <= `AIMUX_SRC_NONE;
			neg_source <= `AIMUX_SRC_NONE;
			diff_result <= 1'b0;
			pin_analog_enable <= `AIMUX_RST_BYTE;
			even_port_input_active <= 1'b0;
			odd_port_input_active <= 1'b0;
			amp_enable <= 1'b0;
			amp_gain_code <= `AIMUX_RST_NIB;
		end else begin
			pos_source <= pos_nxt;
			neg_source <= neg_nxt;
			diff_result <= diff_nxt;
			pin_analog_enable <= pins_r;
			even_port_input_active <= |even_mask;
			odd_port_input_active <= |odd_mask;
			amp_enable <= amp_en_r;
			amp_gain_code <= gain_r;
		end
	end
endmodule

// *** tb/aimux_chk.sv ***
`timescale 1ns/1ns
module aimux_chk (
	input wire clock, srst, sfr_wr, sfr_rd, diff_result,
	input wire even_port_input_active, odd_port_input_active,
	input wire [7:0] sfr_addr, sfr_wdata, sfr_rdata, pin_analog_enable,
	input wire [3:0] pos_source, neg_source
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence s_rel; $fell(srst); endsequence
	sequence s_init; pin_analog_enable == 8'h00 ##1 pos_source == 4'h1 && neg_source == 4'h6; endsequence
	property p_rst; s_rel |-> s_init; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_nib; sfr_rd && sfr_addr[7:1] == 7'h5d |=> sfr_rdata[7:4] == 4'h0; endproperty
	a_nib: assert property (p_nib) else $error("top nibble set");
	property p_pin; sfr_wr && sfr_addr == 8'hbd |-> ##2 pin_analog_enable == $past(sfr_wdata, 2); endproperty
	a_pin: assert property (p_pin) else $error("pin select wrong");
	property p_wire; even_port_input_active == |(pin_analog_enable & 8'h55)
		&& odd_port_input_active == |(pin_analog_enable & 8'haa); endproperty
	a_wire: assert property (p_wire) else $error("port input join wrong");
	property p_fmt; pos_source != 4'h0 |-> diff_result == (neg_source != 4'h6); endproperty
	a_fmt: assert property (p_fmt) else $error("format flag wrong");
	property p_amp; pos_source == 4'h5 && diff_result |-> neg_source == 4'ha; endproperty
	a_amp: assert property (p_amp) else $error("amp reference wrong");
	property p_port; pos_source == 4'h7 && diff_result |-> neg_source == 4'h8; endproperty
	a_port: assert property (p_port) else $error("port pair wrong");
	property p_ext; diff_result && pos_source < 4'h4 |-> neg_source == pos_source + 4'h1; endproperty
	a_ext: assert property (p_ext) else $error("input pair wrong");
endmodule
bind aimux_select aimux_chk aimux_chk_inst (.*);

// *** tb/aimux_adc.sv ***
`timescale 1ns/1ns
module aimux_adc (
	input wire clock, diff_result,
	input wire [3:0] pos_source, neg_source,
	output reg [7:0] conv_word
);
	// source k sits at level 16k; a pair converts to a signed difference
	always @(posedge clock) begin
		conv_word <= {pos_source, 4'h0} - (diff_result ? {neg_source, 4'h0} : 8'h00);
	end
endmodule

// *** tb/tb_aimux_select.sv ***
`timescale 1ns/1ns
module tb_aimux_select;
	logic clock = 1'h0, srst = 1'h1, sfr_wr = 1'h0, sfr_rd = 1'h0, diff_result, amp_enable;
	logic even_port_input_active, odd_port_input_active;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, pin_analog_enable, conv_word;
	logic [3:0] pos_source, neg_source, amp_gain_code;
	logic [11:0] tp [0:7] = '{12'h121, 12'h000, 12'h341, 12'h000, 12'h5a1, 12'h000, 12'h781, 12'h000};
	int bad_count = 0;
	int num_checks = 0;
	always #4 clock = ~clock;
	aimux_select aimux_select_inst (.*);
	aimux_adc aimux_adc_inst (.*);
	task chk(input string n, input logic [11:0] s, e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(negedge clock);
		{sfr_wr, sfr_addr, sfr_wdata} = {1'h1, a, d};
		@(negedge clock);
		sfr_wr = 1'h0;
		repeat (2) @(negedge clock);
	endtask
	task rd(input logic [7:0] a, e);
		@(negedge clock);
		{sfr_rd, sfr_addr} = {1'h1, a};
		@(negedge clock);
		sfr_rd = 1'h0;
		chk("rdata", {4'h0, sfr_rdata}, {4'h0, e});
	endtask
	task close_out;
		if (bad_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clock);
		bad_count++;
		close_out;
	end
	initial begin
		repeat (5) @(negedge clock);
		srst = 1'h0;
		@(negedge clock);
		chk("reset", {pos_source, neg_source, 3'h0, diff_result}, 12'h160);
		rd(8'hbd, 8'h00);
		rd(8'hd6, 8'h00);
		for (int p = 0; p < 16; p += 15) begin
			wr(8'hba, {4'ha, p[3:0]});
			rd(8'hba, p[7:0]);
			for (int c = 0; c < 16; c++) begin
				wr(8'hbb, {4'h5, c[3:0]});
				rd(8'hbb, c[7:0]);
				chk("route", {pos_source, neg_source, 3'h0, diff_result},
					c > 7 ? 12'h960 : p ? tp[c] : {c[3:0] + 4'h1, 8'h60});
			end
		end
		wr(8'hbb, 8'h00);
		repeat (2) @(negedge clock);
		chk("conv", {4'h0, conv_word}, 12'h0f0);
		wr(8'hbd, 8'h41);
		chk("pins", {pin_analog_enable, 2'h0, even_port_input_active,
			odd_port_input_active}, 12'h412);
		wr(8'hd6, 8'hff);
		rd(8'hd6, 8'h8f);
		chk("amp", {7'h0, amp_enable, amp_gain_code}, 12'h01f);
		close_out;
	end
endmodule
